// ### verilog/cbbss_pkg.sv
// package: mode codes, counts and reset values for the channel mode block
package cbbss_pkg;
	localparam int         CHANNELS      = 4;
	localparam int         SSE_CHANNELS  = 2;
	localparam logic [7:0] MODE_RESET    = 8'h00;
	localparam logic [7:0] MODE_ASYNC_BB = 8'h01;
	localparam logic [7:0] MODE_SSE      = 8'h02;
	localparam logic [7:0] MODE_SYNC_BB  = 8'h04;
	localparam logic [7:0] DIR_RESET     = 8'h00;
	localparam logic [7:0] PINS_RESET    = 8'h00;
	localparam int         CLK_MHZ       = 100;
	localparam int         REF_MHZ       = 120;
	localparam int         SCLK_MAX_MHZ  = 30;
	// smallest divider keeping the serial clock at or below its ceiling
	localparam int         SCLK_MIN_DIV  =
		(CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
	localparam int         PRESCALE_W    = 14;
	localparam int         FRAC_W        = 4;
	localparam int         SETUP_CYCLES  = 1;

	typedef enum logic [3:0] {
		CBB_IDLE   = 4'b0001,
		CBB_SAMPLE = 4'b0010,
		CBB_DRIVE  = 4'b0100,
		CBB_SETUP  = 4'b1000
	} cbbss_sync_t;
endpackage : cbbss_pkg

// ### verilog/cbbss_channel.sv
// one channel: mode select, bit-bang engines, serial clock, line enables
`timescale 1ns/100ps

// Notes on behaviour
// - mode codes 0 reset, 1 async bit-bang, 2 serial engine, 4 sync bit-bang.
// - serial engine mode only on channels 0 and 1; others ignore it.
// - in serial engine mode host bytes are taken as a command stream.
// - serial clock at most 30 MHz, slower through a programmable divider.
// - adaptive clocking holds data after clock edge until returned clock seen.
// - adaptive clocking is off after reset until host turns it on.
// - async bit-bang drives host bytes onto output pins on baud ticks.
// - each pin is input or output; only outputs are driven.
// - async outputs change only with new byte and a baud tick.
// - sync outputs update only on host byte; sampling only then.
// - sync bit-bang stalls until the host-bound buffer has room.
// - sync bit-bang samples pins before driving, so reads lag one byte.
// - one setup cycle after driving before the next host byte.
// - read and write strobes are never driven in bit-bang modes.
// - line driver enable only while the UART shifts a character.
// - line driver enable works only when configuration memory enables it.
// - suspend power enable high while suspended, low otherwise.
// - every channel runs its bit-bang modes independently.
// - baud generator uses a 14-bit prescaler plus four fraction bits.
module cbbss_channel #(
	parameter int CH_INDEX = 0
) (
	input  wire logic        I_CLK,            // 100 MHz clock
	input  wire logic        I_SYS_RST,        // async reset, active high
	input  wire logic        I_MODE_WR,        // mode select strobe
	input  wire logic [7:0]  I_MODE_CODE,      // mode code
	input  wire logic [7:0]  I_DIR_MASK,       // pin direction, 1 = output
	input  wire logic        I_ADAPT_EN,       // adaptive clocking request
	input  wire logic [7:0]  I_SCLK_DIV,       // serial clock half period
	input  wire logic [13:0] I_BAUD_PRE,       // baud prescaler
	input  wire logic [3:0]  I_BAUD_FRAC,      // baud fraction sixteenths
	input  wire logic [7:0]  I_RX_DATA,        // host byte
	input  wire logic        I_RX_VALID,       // host byte present
	output logic             o_rx_ready,       // host byte taken
	output logic [7:0]       o_tx_data,        // byte toward host
	output logic             o_tx_valid,       // byte toward host valid
	input  wire logic        I_TX_READY,       // host buffer has room
	input  wire logic [7:0]  I_PIN_IN,         // parallel pins in
	output logic [7:0]       o_pin_out,        // parallel pins out
	output logic [7:0]       o_pin_oe,         // parallel pin enables
	output logic             o_sse_cmd_valid,  // command byte to engine
	output logic [7:0]       o_sse_cmd,        // command byte
	output logic             o_serial_clock_out, // engine clock
	output logic             o_sse_data_step,  // data may change now
	input  wire logic        I_LOW_GPIO_BIT3,  // returned clock pin
	input  wire logic        I_UART_SHIFTING,  // UART shifting a character
	input  wire logic        I_LDE_CFG,        // line driver enable from cfg
	input  wire logic        I_USB_SUSPEND,    // host interface suspended
	output logic             o_suspend_power_enable_n, // high in suspend
	output logic             o_line_driver_enable, // transceiver enable
	output logic             o_strobe_oe,      // strobe pin drive enable
	output logic [7:0]       o_mode            // active mode
);
	//------------------------------------------------------------
	// mode and direction
	//------------------------------------------------------------
	logic [7:0] mode_reg;
	logic [7:0] dir_reg;
	logic       adapt_reg;
	logic       mode_ok;

	assign mode_ok = (I_MODE_CODE == cbbss_pkg::MODE_RESET)
		|| (I_MODE_CODE == cbbss_pkg::MODE_ASYNC_BB)
		|| (I_MODE_CODE == cbbss_pkg::MODE_SYNC_BB)
		|| (I_MODE_CODE == cbbss_pkg::MODE_SSE
			&& CH_INDEX < cbbss_pkg::SSE_CHANNELS);

	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			mode_reg <= cbbss_pkg::MODE_RESET;
			dir_reg  <= cbbss_pkg::DIR_RESET;
		end else if (I_MODE_WR && mode_ok) begin
			mode_reg <= I_MODE_CODE;
			dir_reg  <= I_DIR_MASK;
		end
	end

	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			adapt_reg <= 1'b0;
		end else begin
			adapt_reg <= I_ADAPT_EN && mode_reg == cbbss_pkg::MODE_SSE;
		end
	end

	assign o_mode = mode_reg;
	wire is_async = mode_reg == cbbss_pkg::MODE_ASYNC_BB;
	wire is_sync  = mode_reg == cbbss_pkg::MODE_SYNC_BB;
	wire is_sse   = mode_reg == cbbss_pkg::MODE_SSE;

	//------------------------------------------------------------
	// pin synchronisers
	//------------------------------------------------------------
	logic [7:0] pin_s1_reg, pin_s2_reg;
	logic       returned_clock_s1_reg, returned_clock_s2_reg;
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			pin_s1_reg  <= 8'h00;
			pin_s2_reg  <= 8'h00;
			returned_clock_s1_reg <= 1'b0;
			returned_clock_s2_reg <= 1'b0;
		end else begin
			pin_s1_reg  <= I_PIN_IN;
			pin_s2_reg  <= pin_s1_reg;
			returned_clock_s1_reg <= I_LOW_GPIO_BIT3;
			returned_clock_s2_reg <= returned_clock_s1_reg;
		end
	end

	//------------------------------------------------------------
	// baud generator: integer plus sixteenths accumulator
	//------------------------------------------------------------
	logic [13:0] baud_cnt_reg;
	logic [4:0]  frac_acc_reg;
	logic        baud_tick;
	logic [4:0]  frac_sum;
	assign frac_sum  = frac_acc_reg + {1'b0, I_BAUD_FRAC};
	assign baud_tick = (baud_cnt_reg == 14'h0000);
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			baud_cnt_reg <= 14'h0000;
			frac_acc_reg <= 5'h00;
		end else if (baud_tick) begin
			// a carry out of the fraction stretches this period by one
			frac_acc_reg <= {1'b0, frac_sum[3:0]};
			baud_cnt_reg <= I_BAUD_PRE + {13'h0000, frac_sum[4]};
		end else begin
			baud_cnt_reg <= baud_cnt_reg - 14'h0001;
		end
	end

	//------------------------------------------------------------
	// synchronous bit-bang sequencer
	//------------------------------------------------------------
	cbbss_pkg::cbbss_sync_t st_reg;
	logic [7:0] byte_reg;
	logic [7:0] pins_reg;
	logic [7:0] tx_reg;
	logic       tx_v_reg;

	wire async_take = is_async && I_RX_VALID && baud_tick;
	wire sync_take  = is_sync && st_reg == cbbss_pkg::CBB_IDLE
		&& I_RX_VALID && !tx_v_reg;
	wire sse_take   = is_sse && I_RX_VALID;

	assign o_rx_ready = async_take || sync_take || sse_take;

	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			st_reg   <= cbbss_pkg::CBB_IDLE;
			byte_reg <= 8'h00;
		end else if (!is_sync) begin
			st_reg <= cbbss_pkg::CBB_IDLE;
		end else begin
			case (st_reg)
				cbbss_pkg::CBB_IDLE: begin
					if (sync_take) begin
						byte_reg <= I_RX_DATA;
						st_reg   <= cbbss_pkg::CBB_SAMPLE;
					end
				end
				cbbss_pkg::CBB_SAMPLE: begin
					if (!tx_v_reg) begin
						st_reg <= cbbss_pkg::CBB_DRIVE;
					end
				end
				cbbss_pkg::CBB_DRIVE: st_reg <= cbbss_pkg::CBB_SETUP;
				cbbss_pkg::CBB_SETUP: st_reg <= cbbss_pkg::CBB_IDLE;
				default: st_reg <= cbbss_pkg::CBB_IDLE;
			endcase
		end
	end

	// sample first, then drive: returned byte lags outputs by one
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			tx_reg   <= 8'h00;
			tx_v_reg <= 1'b0;
		end else if (is_sync && st_reg == cbbss_pkg::CBB_SAMPLE
			&& !tx_v_reg) begin
			tx_reg   <= pin_s2_reg;
			tx_v_reg <= 1'b1;
		end else if (tx_v_reg && I_TX_READY) begin
			tx_v_reg <= 1'b0;
		end
	end
	assign o_tx_data  = tx_reg;
	assign o_tx_valid = tx_v_reg;

	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			pins_reg <= cbbss_pkg::PINS_RESET;
		end else if (mode_reg == cbbss_pkg::MODE_RESET) begin
			pins_reg <= cbbss_pkg::PINS_RESET;
		end else if (async_take) begin
			pins_reg <= I_RX_DATA;
		end else if (is_sync && st_reg == cbbss_pkg::CBB_DRIVE) begin
			pins_reg <= byte_reg;
		end
	end

	// only output-configured pins carry data in bit-bang modes
	assign o_pin_out = pins_reg & dir_reg;
	assign o_pin_oe  = (is_async || is_sync) ? dir_reg : 8'h00;
	assign o_strobe_oe = 1'b0;

	//------------------------------------------------------------
	// serial engine: command stream and clock
	//------------------------------------------------------------
	logic [7:0] cmd_reg;
	logic       cmd_v_reg;
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			cmd_reg   <= 8'h00;
			cmd_v_reg <= 1'b0;
		end else begin
			cmd_v_reg <= sse_take;
			if (sse_take) begin
				cmd_reg <= I_RX_DATA;
			end
		end
	end
	assign o_sse_cmd       = cmd_reg;
	assign o_sse_cmd_valid = cmd_v_reg;

	// divider below the ceiling is clamped so the clock never exceeds it
	logic [7:0] half_div;
	logic [7:0] sdiv_cnt_reg;
	logic       sclk_reg;
	logic       wait_returned_clock_reg;
	logic       step_reg;
	assign half_div = (I_SCLK_DIV < 8'(cbbss_pkg::SCLK_MIN_DIV))
		? 8'(cbbss_pkg::SCLK_MIN_DIV) : I_SCLK_DIV;
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			sdiv_cnt_reg  <= 8'h00;
			sclk_reg      <= 1'b0;
			wait_returned_clock_reg <= 1'b0;
			step_reg      <= 1'b0;
		end else if (!is_sse) begin
			sdiv_cnt_reg  <= 8'h00;
			sclk_reg      <= 1'b0;
			wait_returned_clock_reg <= 1'b0;
			step_reg      <= 1'b0;
		end else if (wait_returned_clock_reg) begin
			step_reg <= 1'b0;
			if (returned_clock_s2_reg == sclk_reg) begin
				wait_returned_clock_reg <= 1'b0;
				step_reg      <= 1'b1;
			end
		end else if (sdiv_cnt_reg + 8'h01 >= half_div) begin
			sdiv_cnt_reg  <= 8'h00;
			sclk_reg      <= !sclk_reg;
			wait_returned_clock_reg <= adapt_reg && !sclk_reg;
			step_reg      <= !adapt_reg && sclk_reg;
		end else begin
			sdiv_cnt_reg <= sdiv_cnt_reg + 8'h01;
			step_reg     <= 1'b0;
		end
	end
	assign o_serial_clock_out = sclk_reg;
	assign o_sse_data_step    = step_reg;

	//------------------------------------------------------------
	// line driver enable
	//------------------------------------------------------------
	assign o_line_driver_enable = I_LDE_CFG
		&& mode_reg == cbbss_pkg::MODE_RESET
		&& I_UART_SHIFTING;

	// lets external transceivers drop to low quiescent current
	assign o_suspend_power_enable_n = I_USB_SUSPEND;

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	property p_sync_setup;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(is_sync && st_reg == cbbss_pkg::CBB_DRIVE)
			|=> !o_rx_ready ##1 st_reg == cbbss_pkg::CBB_IDLE;
	endproperty
	a_sync_setup: assert property (p_sync_setup)
		else $error("sync setup cycle skipped");

	property p_sample_before_drive;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(is_sync && st_reg == cbbss_pkg::CBB_DRIVE)
			|-> $stable(pins_reg);
	endproperty
	a_sample_before_drive: assert property (p_sample_before_drive)
		else $error("pins changed before sample");

	property p_async_hold;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(is_async && !$past(async_take)) |-> $stable(pins_reg);
	endproperty
	a_async_hold: assert property (p_async_hold)
		else $error("async pins changed without tick");

	property p_no_sse_high;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(CH_INDEX >= cbbss_pkg::SSE_CHANNELS) |-> !is_sse;
	endproperty
	a_no_sse_high: assert property (p_no_sse_high)
		else $error("serial engine on high channel");

	property p_adapt_hold;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		wait_returned_clock_reg && returned_clock_s2_reg != sclk_reg
			|=> !o_sse_data_step && $stable(sclk_reg);
	endproperty
	a_adapt_hold: assert property (p_adapt_hold)
		else $error("data stepped before returned clock");

	property p_stall;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		tx_v_reg && is_sync |-> !sync_take;
	endproperty
	a_stall: assert property (p_stall)
		else $error("byte taken while host buffer full");

	property p_oe_mask;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(o_pin_out & ~dir_reg) == 8'h00 && !o_strobe_oe;
	endproperty
	a_oe_mask: assert property (p_oe_mask)
		else $error("input pin driven");

	property p_lde;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		o_line_driver_enable |-> I_LDE_CFG && I_UART_SHIFTING;
	endproperty
	a_lde: assert property (p_lde)
		else $error("line driver enabled without cause");

	property p_adapt_reset;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		!is_sse |=> !adapt_reg;
	endproperty
	a_adapt_reset: assert property (p_adapt_reset)
		else $error("adaptive clocking on outside engine");
endmodule : cbbss_channel

// ### sim/cbbss_target.sv
// partner model: parallel target with pull-ups and a returned clock
`timescale 1ns/100ps
module cbbss_target (
	input  wire logic       i_clk,   // clock
	input  wire logic [7:0] i_pins,  // pins driven by the channel
	input  wire logic [7:0] i_oe,    // pin drive enables
	input  wire logic       i_sclk,  // serial clock from the channel
	input  wire logic       i_stall, // target slow: freeze returned clock
	output logic [7:0]      o_pins,  // pin levels seen by the channel
	output logic            o_returned_clock   // returned clock
);
	logic returned_clock_reg = 1'b0;

	// undriven pins float high through pull-ups
	assign o_pins = (i_pins & i_oe) | ~i_oe;
	assign o_returned_clock = returned_clock_reg;

	// a slow target leaves the returned clock frozen, not echoed
	always @(posedge i_clk) begin
		if (!i_stall) begin
			returned_clock_reg <= i_sclk;
		end
	end
endmodule : cbbss_target

// ### sim/channel_bitbang_sync_serial_modes_bench.sv
// bench: mode select, bit-bang, serial engine and line enable checks
`timescale 1ns/100ps
module channel_bitbang_sync_serial_modes_bench;
	logic       i_clk     = 1'b0;
	logic       i_rst     = 1'b1;
	logic       mode_wr   = 1'b0;
	logic [7:0] mode_code = 8'h00;
	logic [7:0] dir_mask  = 8'h00;
	logic       adapt     = 1'b0;
	logic [7:0] rx_data   = 8'h00;
	logic       rx_valid  = 1'b0;
	logic       tx_ready  = 1'b1;
	logic       shifting  = 1'b0;
	logic       lde_cfg   = 1'b0;
	logic       stall     = 1'b0;
	logic       suspend   = 1'b0;
	logic       pwr_n;
	logic [7:0]  sclk_div  = 8'h00;
	logic [13:0] baud_pre  = 14'h0003;
	logic [3:0]  baud_frac = 4'h0;
	logic       rx_ready, tx_valid, cmd_valid, sclk, step, lde, strobe_oe;
	logic       returned_clock;
	logic [7:0] tx_data, pin_out, pin_oe, cmd, mode, mode2, pin_in;
	logic [7:0] cmd_seen  = 8'h00;
	logic [7:0] got[$];
	int         n_mismatch = 0;
	int         tests_run  = 0;
	int         cyc        = 0;
	int         last_take  = 0;
	int         gap        = 0;
	int         r;

	always #5 i_clk = ~i_clk;

	cbbss_channel #(.CH_INDEX(0)) i_cbbss_channel (
		.I_CLK(i_clk), .I_SYS_RST(i_rst), .I_MODE_WR(mode_wr),
		.I_MODE_CODE(mode_code), .I_DIR_MASK(dir_mask), .I_ADAPT_EN(adapt),
		.I_SCLK_DIV(sclk_div), .I_BAUD_PRE(baud_pre),
		.I_BAUD_FRAC(baud_frac), .I_USB_SUSPEND(suspend),
		.o_suspend_power_enable_n(pwr_n),
		.I_RX_DATA(rx_data), .I_RX_VALID(rx_valid), .o_rx_ready(rx_ready),
		.o_tx_data(tx_data), .o_tx_valid(tx_valid), .I_TX_READY(tx_ready),
		.I_PIN_IN(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
		.o_sse_cmd_valid(cmd_valid), .o_sse_cmd(cmd),
		.o_serial_clock_out(sclk), .o_sse_data_step(step),
		.I_LOW_GPIO_BIT3(returned_clock), .I_UART_SHIFTING(shifting),
		.I_LDE_CFG(lde_cfg), .o_line_driver_enable(lde),
		.o_strobe_oe(strobe_oe), .o_mode(mode));

	// third channel shares the stimulus; only its mode is watched
	cbbss_channel #(.CH_INDEX(2)) i_cbbss_channel_c (
		.I_CLK(i_clk), .I_SYS_RST(i_rst), .I_MODE_WR(mode_wr),
		.I_MODE_CODE(mode_code), .I_DIR_MASK(dir_mask), .I_ADAPT_EN(adapt),
		.I_SCLK_DIV(sclk_div), .I_BAUD_PRE(baud_pre),
		.I_BAUD_FRAC(baud_frac), .I_USB_SUSPEND(suspend),
		.o_suspend_power_enable_n(),
		.I_RX_DATA(rx_data), .I_RX_VALID(1'b0), .o_rx_ready(),
		.o_tx_data(), .o_tx_valid(), .I_TX_READY(tx_ready),
		.I_PIN_IN(pin_in), .o_pin_out(), .o_pin_oe(),
		.o_sse_cmd_valid(), .o_sse_cmd(), .o_serial_clock_out(),
		.o_sse_data_step(), .I_LOW_GPIO_BIT3(returned_clock), .I_UART_SHIFTING(shifting),
		.I_LDE_CFG(lde_cfg), .o_line_driver_enable(), .o_strobe_oe(),
		.o_mode(mode2));

	cbbss_target i_cbbss_target (
		.i_clk(i_clk), .i_pins(pin_out), .i_oe(pin_oe), .i_sclk(sclk),
		.i_stall(stall), .o_pins(pin_in), .o_returned_clock(returned_clock));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic end_of_test();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string what, input logic [7:0] exp, act);
		tests_run++;
		if (act !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, act);
			n_mismatch++;
		end
	endtask : chk

	task automatic set_mode(input logic [7:0] code, input logic [7:0] dir);
		@(negedge i_clk);
		mode_code = code;
		dir_mask = dir;
		mode_wr = 1'b1;
		@(negedge i_clk);
		mode_wr = 1'b0;
		@(negedge i_clk);
	endtask : set_mode

	// ready is looked at on settled falling edges; the take is the next rise
	task automatic send(input logic [7:0] b);
		int n;
		n = 0;
		@(negedge i_clk);
		rx_data = b;
		rx_valid = 1'b1;
		#1;
		while (rx_ready !== 1'b1 && n < 200) begin
			@(negedge i_clk);
			n++;
		end
		chk("take", 8'h01, 8'(n < 200));
		@(negedge i_clk);
		rx_valid = 1'b0;
		gap = cyc - last_take;
		last_take = cyc;
	endtask : send

	task automatic count_sclk(output int t);
		logic last;
		t = 0;
		last = sclk;
		repeat (40) begin
			@(negedge i_clk);
			if (sclk !== last) t++;
			last = sclk;
		end
	endtask : count_sclk

	always @(posedge i_clk) begin
		cyc++;
		if (tx_valid === 1'b1 && tx_ready) got.push_back(tx_data);
		if (cmd_valid === 1'b1) cmd_seen <= cmd;
		if (cyc > 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		i_rst = 1'b0;
		chk("mode", 8'h00, mode);
		chk("oe", 8'h00, pin_oe);
		set_mode(8'h02, 8'h00);
		chk("mode", 8'h02, mode);
		chk("mode2", 8'h00, mode2);
		stall = 1'b1;
		count_sclk(r);
		chk("sclk", 8'h01, 8'(r > 0 && r <= 20));
		adapt = 1'b1;
		count_sclk(r);
		count_sclk(r);
		chk("adapt", 8'h01, 8'(r <= 1));
		stall = 1'b0;
		count_sclk(r);
		chk("resume", 8'h01, 8'(r > 0));
		adapt = 1'b0;
		send(8'h3C);
		@(negedge i_clk);
		chk("cmd", 8'h3C, cmd_seen);
		send(8'hC3);
		@(negedge i_clk);
		chk("cmd", 8'hC3, cmd_seen);
		suspend = 1'b1;
		#1;
		chk("pwr", 8'h01, 8'(pwr_n));
		suspend = 1'b0;
		#1;
		chk("pwr", 8'h00, 8'(pwr_n));
		set_mode(8'h00, 8'h00);
		lde_cfg = 1'b1;
		shifting = 1'b1;
		@(negedge i_clk);
		chk("lde", 8'h01, 8'(lde));
		shifting = 1'b0;
		@(negedge i_clk);
		chk("lde", 8'h00, 8'(lde));
		shifting = 1'b1;
		lde_cfg = 1'b0;
		@(negedge i_clk);
		chk("lde", 8'h00, 8'(lde));
		set_mode(8'h01, 8'h0F);
		chk("mode2", 8'h01, mode2);
		chk("oe", 8'h0F, pin_oe);
		send(8'hA5);
		repeat (2) @(negedge i_clk);
		chk("async", 8'h05, pin_out);
		repeat (20) @(negedge i_clk);
		chk("hold", 8'h05, pin_out);
		chk("strobe", 8'h00, 8'(strobe_oe));
		set_mode(8'h00, 8'h00);
		chk("clear", 8'h00, pin_out);
		set_mode(8'h04, 8'hFF);
		got.delete();
		tx_ready = 1'b0;
		send(8'h55);
		@(negedge i_clk);
		rx_data = 8'hAA;
		rx_valid = 1'b1;
		repeat (10) @(negedge i_clk);
		chk("stall", 8'h00, 8'(rx_ready));
		chk("pend", 8'h01, 8'(tx_valid));
		chk("sync", 8'h55, pin_out);
		tx_ready = 1'b1;
		send(8'hAA);
		send(8'hAA);
		chk("gap", 8'h01, 8'(gap >= 4));
		repeat (10) @(negedge i_clk);
		chk("count", 8'h03, 8'(got.size()));
		while (got.size() < 3) got.push_back(8'hXX);
		chk("ret0", 8'h00, got[0]);
		chk("ret1", 8'h55, got[1]);
		chk("ret2", 8'hAA, got[2]);
		chk("sync", 8'hAA, pin_out);
		chk("strobe", 8'h00, 8'(strobe_oe));
		end_of_test();
	end
endmodule : channel_bitbang_sync_serial_modes_bench
